// ===== rtl/otp_prog_map.svh
`ifndef OTP_PROG_MAP_SVH
`define OTP_PROG_MAP_SVH
// ******************************************
// timing figures and counts
// ******************************************
`define OTP_CLK_MHZ 50
// program pulse nominal width in us, window is 47.5 .. 52.5 us
`define OTP_PW_NOM_US 50
`define OTP_PW_CYC (`OTP_PW_NOM_US * `OTP_CLK_MHZ)
// setup times (address, data, oe, supply) in us
`define OTP_SETUP_US 2
`define OTP_SETUP_CYC (`OTP_SETUP_US * `OTP_CLK_MHZ)
// data valid from output enable, max ns (round up to cycles)
`define OTP_TOE_NS 150
`define OTP_TOE_CYC ((`OTP_TOE_NS + 19) / 20 + 1)
// output float after output enable high, max ns
`define OTP_TDFP_NS 130
`define OTP_TDFP_CYC ((`OTP_TDFP_NS + 19) / 20 + 1)
// extra pulses allowed after the blind one
`define OTP_MAX_RETRY 4'ha
// address range
`define OTP_ADDR_W 17
`define OTP_LAST_ADDR 17'h1_ffff
`define OTP_ID_SEL_BIT 0
`define OTP_CNT_W 16
`endif

// ===== rtl/otp_prog_pkg.sv
package otp_prog_pkg;
  // sequencer states
  typedef enum logic [3:0] {
    OTP_IDLE    = 4'b0000,
    OTP_SETUP   = 4'b0001,
    OTP_PULSE   = 4'b0010,
    OTP_PGAP    = 4'b0011,
    OTP_VOE     = 4'b0100,
    OTP_VFLT    = 4'b0101,
    OTP_NEXT    = 4'b0110,
    OTP_RB_OE   = 4'b0111,
    OTP_RB_FLT  = 4'b1000,
    OTP_DONE    = 4'b1001
  } otp_state_t;
  // command encodings
  typedef enum logic [1:0] {
    OTP_CMD_PROG = 2'b00,
    OTP_CMD_ID   = 2'b01,
    OTP_CMD_READ = 2'b10
  } otp_cmd_t;
endpackage : otp_prog_pkg

// ===== rtl/otp_prog_host.sv
// Notes on behaviour
// - start at first address, one blind pulse
// - failing word gets up to ten more pulses after the blind one
// - still failing after ten: part failed
// - passing word advances until all checked
// - supplies back to 5V, compare every word
// - program pulse lasts 47.5 to 52.5 us
// - wait 150 ns data, 130 ns float
// - id mode: ce, oe low, high-voltage line
`timescale 1ns/10ps
`default_nettype none
`include "otp_prog_map.svh"
module otp_prog_host
  import otp_prog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,                   // one-cycle command strobe
  input wire logic [1:0] cmd_i,               // otp_cmd_t
  input wire logic [`OTP_ADDR_W-1:0] last_addr_i, // last address to handle
  input wire logic [15:0] src_data_i,         // source word for addr_o
  input wire logic [15:0] dev_data_i,         // device output pins
  output logic [`OTP_ADDR_W-1:0] addr_o,      // device address pins
  output logic [15:0] prog_data_o,            // data driven in program
  output logic prog_data_oe_o,                // high while host drives data
  output logic chip_en_n_o,
  output logic out_en_n_o,
  output logic program_strobe_n_o,
  output logic prog_volts_o,                  // high: vcc 6.5, vpp 13.0
  output logic id_mode_address_line_hv_o,     // high: id line at 12 V
  output logic busy_o,
  output logic done_o,                        // one-cycle pulse at end
  output logic fail_o,                        // level until next start
  output logic [15:0] id_word_o               // captured id or read word
);
  // ******************************************
  // input synchronisers
  // ******************************************
  logic [15:0] din_s1;
  logic [15:0] din_s2;
  logic [15:0] next_din_s1;
  logic [15:0] next_din_s2;
  // two stages because the pins are asynchronous to clk_i
  always_comb begin
    next_din_s1 = dev_data_i;
    next_din_s2 = din_s1;
  end
  always_ff @(posedge clk_i) begin
    din_s1 <= next_din_s1;
    din_s2 <= next_din_s2;
  end
  // ******************************************
  // sequencer
  // ******************************************
  otp_state_t state, next_state;
  otp_cmd_t mode, next_mode;
  logic [`OTP_CNT_W-1:0] cnt, next_cnt;       // cycle timer
  logic [3:0] tries, next_tries;              // extra pulses given
  logic blind, next_blind;                    // first pulse of a word
  logic [`OTP_ADDR_W-1:0] addr, next_addr;
  logic [`OTP_ADDR_W-1:0] last, next_last;
  logic ce_n, next_ce_n, oe_n, next_oe_n, pgm_n, next_pgm_n;
  logic dro, next_dro, pv, next_pv, hv, next_hv;
  logic busy, next_busy, done, next_done, fail, next_fail;
  logic [15:0] pd, next_pd, idw, next_idw;
  logic tdone;
  assign tdone = (cnt == '0);
  // next state and pin values
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_cnt = tdone ? cnt : cnt - 1'b1;
    next_tries = tries;
    next_blind = blind;
    next_addr = addr;
    next_last = last;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_pgm_n = pgm_n;
    next_dro = dro;
    next_pv = pv;
    next_hv = hv;
    next_busy = busy;
    next_done = 1'b0;
    next_fail = fail;
    next_pd = pd;
    next_idw = idw;
    case (state)
      OTP_IDLE: begin
        if (start_i) begin
          next_mode = otp_cmd_t'(cmd_i);
          next_addr = '0;
          next_last = last_addr_i;
          if (otp_cmd_t'(cmd_i) == OTP_CMD_ID) begin
            // one id word per command, picked by the select bit of last_addr_i
            next_addr = `OTP_ADDR_W'(last_addr_i[`OTP_ID_SEL_BIT]);
            next_last = `OTP_ADDR_W'(last_addr_i[`OTP_ID_SEL_BIT]);
          end
          next_busy = 1'b1;
          next_fail = 1'b0;
          next_blind = 1'b1;
          next_tries = '0;
          next_ce_n = 1'b0;
          next_pv = (otp_cmd_t'(cmd_i) == OTP_CMD_PROG);
          next_hv = (otp_cmd_t'(cmd_i) == OTP_CMD_ID);
          next_cnt = `OTP_CNT_W'(`OTP_SETUP_CYC);
          next_state = OTP_SETUP;
        end
      end
      OTP_SETUP: begin
        // supply and address setup before first action; data goes out with the strobe
        if (tdone) begin
          if (mode == OTP_CMD_PROG) begin
            next_pd = src_data_i;
            next_dro = 1'b1;
            next_pgm_n = 1'b0;
            next_cnt = `OTP_CNT_W'(`OTP_PW_CYC);
            next_state = OTP_PULSE;
          end else begin
            next_oe_n = 1'b0;
            next_cnt = `OTP_CNT_W'(`OTP_TOE_CYC);
            next_state = OTP_RB_OE;
          end
        end
      end
      OTP_PULSE: begin
        // the strobe stays low the nominal width plus one clock
        if (tdone) begin
          next_pgm_n = 1'b1;
          next_cnt = `OTP_CNT_W'(`OTP_SETUP_CYC);
          next_state = OTP_PGAP;
        end
      end
      OTP_PGAP: begin
        // data hold, then release bus; the blind pulse is checked like every retry,
        // and a failing check after it opens the retry loop
        if (tdone) begin
          next_dro = 1'b0;
          if (blind) begin
            next_blind = 1'b0;
          end
          next_oe_n = 1'b0;
          next_cnt = `OTP_CNT_W'(`OTP_TOE_CYC);
          next_state = OTP_VOE;
        end
      end
      OTP_VOE: begin
        // sample only after data valid time plus sync latency
        if (tdone) begin
          next_oe_n = 1'b1;
          next_cnt = `OTP_CNT_W'(`OTP_TDFP_CYC);
          if (din_s2 == pd) begin
            next_state = OTP_NEXT;
          end else if (tries == `OTP_MAX_RETRY) begin
            next_fail = 1'b1;
            next_state = OTP_DONE;
          end else begin
            next_tries = tries + 4'h1;
            next_state = OTP_VFLT;
          end
        end
      end
      OTP_VFLT: begin
        // let outputs float before driving data again
        if (tdone) begin
          next_dro = 1'b1;
          next_pgm_n = 1'b0;
          next_cnt = `OTP_CNT_W'(`OTP_PW_CYC);
          next_state = OTP_PULSE;
        end
      end
      OTP_NEXT: begin
        if (tdone) begin
          if (addr == last) begin
            // all words verified: drop supplies, read everything back
            next_pv = 1'b0;
            next_addr = '0;
            next_mode = OTP_CMD_READ;
            next_cnt = `OTP_CNT_W'(`OTP_SETUP_CYC);
            next_state = OTP_SETUP;
          end else begin
            next_addr = addr + 1'b1;
            next_blind = 1'b1;
            next_tries = '0;
            next_cnt = `OTP_CNT_W'(`OTP_SETUP_CYC);
            next_state = OTP_SETUP;
            next_mode = OTP_CMD_PROG;
          end
        end
      end
      OTP_RB_OE: begin
        if (tdone) begin
          next_oe_n = 1'b1;
          next_idw = din_s2;
          if (mode == OTP_CMD_READ && din_s2 != src_data_i && pv == 1'b0 && hv == 1'b0) begin
            next_fail = 1'b1;
          end
          next_cnt = `OTP_CNT_W'(`OTP_TDFP_CYC);
          next_state = OTP_RB_FLT;
        end
      end
      OTP_RB_FLT: begin
        if (tdone) begin
          if (addr == last) begin
            // id commands end here too, having read their one word
            next_state = OTP_DONE;
          end else begin
            next_addr = addr + 1'b1;
            next_oe_n = 1'b0;
            next_cnt = `OTP_CNT_W'(`OTP_TOE_CYC);
            next_state = OTP_RB_OE;
          end
        end
      end
      OTP_DONE: begin
        next_ce_n = 1'b1;
        next_oe_n = 1'b1;
        next_pgm_n = 1'b1;
        next_dro = 1'b0;
        next_pv = 1'b0;
        next_hv = 1'b0;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = OTP_IDLE;
      end
      default: begin
        next_state = OTP_IDLE;
      end
    endcase
  end
  // registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= OTP_IDLE;
      mode <= OTP_CMD_PROG;
      cnt <= '0;
      tries <= '0;
      blind <= 1'b0;
      addr <= '0;
      last <= '0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      pgm_n <= 1'b1;
      dro <= 1'b0;
      pv <= 1'b0;
      hv <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      pd <= '0;
      idw <= '0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      cnt <= next_cnt;
      tries <= next_tries;
      blind <= next_blind;
      addr <= next_addr;
      last <= next_last;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      pgm_n <= next_pgm_n;
      dro <= next_dro;
      pv <= next_pv;
      hv <= next_hv;
      busy <= next_busy;
      done <= next_done;
      fail <= next_fail;
      pd <= next_pd;
      idw <= next_idw;
    end
  end
  // ******************************************
  // outputs, all straight from flip-flops
  // ******************************************
  assign addr_o = addr;
  assign prog_data_o = pd;
  assign prog_data_oe_o = dro;
  assign chip_en_n_o = ce_n;
  assign out_en_n_o = oe_n;
  assign program_strobe_n_o = pgm_n;
  assign prog_volts_o = pv;
  assign id_mode_address_line_hv_o = hv;
  assign busy_o = busy;
  assign done_o = done;
  assign fail_o = fail;
  assign id_word_o = idw;
endmodule : otp_prog_host
`default_nettype wire

// ===== tb/otp_prog_host_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "otp_prog_map.svh"
module otp_prog_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic busy_o,
  input wire logic [`OTP_ADDR_W-1:0] addr_o,
  input wire logic prog_data_oe_o,
  input wire logic chip_en_n_o,
  input wire logic out_en_n_o,
  input wire logic program_strobe_n_o,
  input wire logic prog_volts_o,
  input wire logic id_mode_address_line_hv_o,
  input wire logic fail_o
);
  // ****************
  // helper counters
  // ****************
  logic [11:0] low_cnt; // cycles the strobe has been low
  logic [4:0] pulse_cnt; // pulses given to the current address
  logic strobe_q; // strobe one cycle ago
  logic [`OTP_ADDR_W-1:0] addr_q; // address one cycle ago
  logic seen; // some pulse given since busy rose
  // counters restart on reset so no stale count leaks into a new run
  always_ff @(posedge clk_i) begin
    strobe_q <= program_strobe_n_o;
    addr_q <= addr_o;
    if (rst_i || program_strobe_n_o) low_cnt <= 12'h000;
    else low_cnt <= low_cnt + 12'h001;
    if (rst_i || !busy_o || addr_o != addr_q) pulse_cnt <= 5'h00;
    else if (strobe_q && !program_strobe_n_o) pulse_cnt <= pulse_cnt + 5'h01;
    if (rst_i || !busy_o) seen <= 1'b0;
    else if (!program_strobe_n_o) seen <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************
  // assertions
  // ****************
  a_pulse_width_ok: assert property ($rose(program_strobe_n_o) |->
    low_cnt >= 12'd2375 && low_cnt <= 12'd2625) else $error("pulse width out of window");
  a_pulse_supplies: assert property (!program_strobe_n_o |->
    prog_volts_o && out_en_n_o && !chip_en_n_o) else $error("pulse without supplies");
  a_first_at_zero: assert property (!program_strobe_n_o && !seen |->
    addr_o == 17'h0_0000) else $error("first pulse not at address zero");
  a_retry_bound: assert property (pulse_cnt <= 5'd11)
    else $error("too many pulses on one word");
  a_verify_after: assert property ($rose(program_strobe_n_o) |->
    ##[1:300] $fell(out_en_n_o)) else $error("no verify after pulse");
  a_verify_wait: assert property ($fell(out_en_n_o) |-> !out_en_n_o [*8])
    else $error("data sampled too early");
  a_float_wait: assert property ($rose(out_en_n_o) |-> !prog_data_oe_o [*7])
    else $error("data driven before float");
  a_no_clash: assert property (!out_en_n_o |-> !prog_data_oe_o)
    else $error("host drives data while device outputs");
  a_id_lines: assert property (id_mode_address_line_hv_o |->
    addr_o[16:1] == 16'h0000 && !prog_volts_o) else $error("bad id mode pins");
  c_fail_seen: cover property ($rose(fail_o));
  c_retry_seen: cover property (pulse_cnt == 5'd3);
  c_id_seen: cover property ($rose(id_mode_address_line_hv_o));
endmodule : otp_prog_chk
bind otp_prog_host otp_prog_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .busy_o(busy_o),
  .addr_o(addr_o), .prog_data_oe_o(prog_data_oe_o), .chip_en_n_o(chip_en_n_o),
  .out_en_n_o(out_en_n_o), .program_strobe_n_o(program_strobe_n_o),
  .prog_volts_o(prog_volts_o), .id_mode_address_line_hv_o(id_mode_address_line_hv_o),
  .fail_o(fail_o));
`default_nettype wire

// ===== tb/otp_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module otp_dev_model #(
  parameter logic [15:0] ID_MAKER = 16'h0a5c, // arbitrary value
  parameter logic [15:0] ID_TYPE = 16'h0c3a // arbitrary value
) (
  input wire logic [16:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic program_strobe_n_i,
  input wire logic prog_volts_i,
  input wire logic hv_i,
  output logic [15:0] data_o
);
  // ****************
  // cell array
  // ****************
  int need [4]; // pulses a word needs before it holds
  int pulses [4] = '{0, 0, 0, 0}; // pulses seen per word
  logic [15:0] mem [4] = '{4{16'hffff}}; // erased words read all ones
  logic [15:0] rd; // word the outputs would show
  logic [15:0] q = 16'h0000; // released-bus pattern
  // a word only takes hold after enough pulses at programming supplies
  always @(posedge program_strobe_n_i) begin
    if (!ce_n_i && prog_volts_i) begin
      pulses[addr_i[1:0]]++;
      if (pulses[addr_i[1:0]] >= need[addr_i[1:0]]) mem[addr_i[1:0]] = data_i;
    end
  end
  // id words need the high-voltage line and all upper address lines low
  assign rd = (hv_i && addr_i[16:1] == 16'h0000) ?
    (addr_i[0] ? ID_TYPE : ID_MAKER) : mem[addr_i[1:0]];
  // a released bus shows the inverse, so a stale word never passes
  always @(posedge oe_n_i or posedge ce_n_i) q <= ~rd;
  // worst-case answer: data valid only 150 ns after the enables, the host's limit
  assign #150 data_o = (!ce_n_i && !oe_n_i) ? rd : q;
endmodule : otp_dev_model
`default_nettype wire

// ===== tb/test_otp_word_program_sequence.sv
`timescale 1ns/10ps
`default_nettype none
`include "otp_prog_map.svh"
module test_otp_word_program_sequence;
  import otp_prog_pkg::*;
  localparam logic [15:0] ID_MAKER = 16'h0a5c; // arbitrary value
  localparam logic [15:0] ID_TYPE = 16'h0c3a; // arbitrary value
  logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0;
  logic [1:0] cmd_i = 2'h0;
  logic [`OTP_ADDR_W-1:0] last_a = '0, addr;
  logic [15:0] src [4], src_d, dev_d, pdat, idw, bus, mask = 16'h0000;
  logic pdoe, ce_n, oe_n, pgm_n, pv, hv, busy, done, fail;
  logic [31:0] xs_s = 32'ha8d6024a; // xorshift state
  int errors = 0, check_count = 0;
  int nd [4] = '{1, 3, 99, 1}; // pulses each word needs
  int ep [4] = '{0, 0, 0, 0}; // expected pulse totals
  bit pg [4] = '{0, 0, 0, 0}; // words expected to hold
  // ****************
  // clock, wiring, parts
  // ****************
  initial forever #10 clk_i = ~clk_i;
  assign src_d = src[addr[1:0]] ^ (addr[1:0] == 2'h1 ? mask : 16'h0000);
  assign bus = pdoe ? pdat : ~pdat; // undriven data never repeats a value
  otp_prog_host uut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .cmd_i(cmd_i),
    .last_addr_i(last_a), .src_data_i(src_d), .dev_data_i(dev_d), .addr_o(addr),
    .prog_data_o(pdat), .prog_data_oe_o(pdoe), .chip_en_n_o(ce_n), .out_en_n_o(oe_n),
    .program_strobe_n_o(pgm_n), .prog_volts_o(pv), .id_mode_address_line_hv_o(hv),
    .busy_o(busy), .done_o(done), .fail_o(fail), .id_word_o(idw));
  otp_dev_model #(.ID_MAKER(ID_MAKER), .ID_TYPE(ID_TYPE)) dev (.addr_i(addr), .data_i(bus),
    .ce_n_i(ce_n),
    .oe_n_i(oe_n), .program_strobe_n_i(pgm_n), .prog_volts_i(pv), .hv_i(hv),
    .data_o(dev_d));
  // ****************
  // tasks
  // ****************
  function automatic logic [31:0] xs();
    xs_s ^= xs_s << 13;
    xs_s ^= xs_s >> 17;
    xs_s ^= xs_s << 5;
    return xs_s;
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // one command; poke tries a second start while busy, which must be ignored
  task automatic run(input logic [1:0] c, input int la, input bit poke);
    int n;
    @(posedge clk_i) #2;
    cmd_i = c;
    last_a = la[16:0];
    start_i = 1'b1;
    @(posedge clk_i) #2;
    start_i = 1'b0;
    chk(busy, 1);
    for (n = 0; n < 60000 && done !== 1'b1; n++) begin
      @(posedge clk_i) #2;
      start_i = poke && n == 5;
      if (poke && n == 5) cmd_i = OTP_CMD_ID;
    end
    if (n == 60000) begin
      errors++;
      $display("BAD %0t no completion", $time);
      end_of_test();
    end
    chk(busy, 0);
  endtask : run
  // bench model of the pulse loop: blind pulse, retries up to ten more
  task automatic expect_prog(input int la);
    bit bad;
    bad = 0;
    for (int i = 0; i <= la; i++) begin
      ep[i] += pg[i] ? 1 : (nd[i] > 11 ? 11 : nd[i]);
      pg[i] = pg[i] | (nd[i] <= 11);
      bad |= !pg[i];
      chk(dev.pulses[i], ep[i]);
    end
    chk(fail, bad);
  endtask : expect_prog
  // ****************
  // main sequence
  // ****************
  initial begin
    // an all-ones word would pass its check with no pulse taking hold
    for (int i = 0; i < 4; i++) src[i] = 16'(xs()) & 16'hfffe;
    dev.need = nd;
    repeat (6) @(posedge clk_i);
    #2 rst_i = 1'b0;
    run(OTP_CMD_ID, 0, 0);
    chk(idw, ID_MAKER);
    chk(fail, 0);
    run(OTP_CMD_ID, 1, 0);
    chk(idw, ID_TYPE);
    $display("test id done");
    run(OTP_CMD_PROG, 1, 1);
    expect_prog(1);
    chk(idw, src[1]);
    $display("test program done");
    mask = 16'h0100;
    run(OTP_CMD_READ, 1, 0);
    chk(fail, 1);
    mask = 16'h0000;
    $display("test read-back done");
    run(OTP_CMD_PROG, 2, 0);
    expect_prog(2);
    chk(dev.pulses[3], 0);
    $display("test failing part done");
    end_of_test();
  end
endmodule : test_otp_word_program_sequence
`default_nettype wire
